// *** pkg/mcs_pkg.sv ***
// Constants, register map and carrier types of the MAC config/status block
package mcs_pkg;
  // Register offsets on the 5-bit local bus
  localparam logic [4:0] OFS_TX_STATUS = 5'h04;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h07;
  localparam logic [4:0] OFS_RX_CFG_STAT = 5'h0c;
  localparam logic [4:0] OFS_TX_CONFIG = 5'h0d;
  localparam logic [4:0] OFS_DATA_CONFIG = 5'h0e;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h0f;
  localparam logic [4:0] OFS_GAP_ONE = 5'h12;
  localparam logic [4:0] OFS_GAP_TWO = 5'h13;
  localparam logic [4:0] OFS_FRAME_GAP = 5'h16;
  // Values after reset
  localparam logic [6:0] RST_GAP_ONE = 7'h0c;
  localparam logic [6:0] RST_GAP_TWO = 7'h12;
  localparam logic [6:0] RST_FRAME_GAP = 7'h15;
  localparam logic [6:0] RST_IRQ_MASK = 7'h00;
  localparam logic RST_IRQ_POLARITY = 1'b1;
  // Interrupt status and mask bit positions
  localparam int IRQ_BIT_DMA = 6;
  localparam int IRQ_BIT_CNT = 5;
  localparam int IRQ_BIT_OVW = 4;
  localparam int IRQ_BIT_TXE = 3;
  localparam int IRQ_BIT_RXE = 2;
  localparam int IRQ_BIT_PTX = 1;
  localparam int IRQ_BIT_PRX = 0;
  // Shortest frame before padding, in bytes
  localparam logic [6:0] MIN_FRAME_BYTES = 7'h3c;
  // Depth of the receive report queue
  localparam int RX_RPT_DEPTH = 4;

  typedef enum logic [1:0] {
    MCS_LB_NORMAL = 2'b00,
    MCS_LB_INTERNAL = 2'b01,
    MCS_LB_PHY = 2'b10,
    MCS_LB_RSVD = 2'b11
  } mcs_loop_e;

  // Receive report, packed in register bit order 6..0
  typedef struct packed {
    logic receiver_off_flag;
    logic multicast_seen_flag;
    logic missed_frame_flag;
    logic rx_buffer_overrun_flag;
    logic alignment_error_flag;
    logic checksum_bad_flag;
    logic rx_intact_flag;
  } mcs_rx_rpt_s;

  // Transmit report
  typedef struct packed {
    logic late_window_hit;
    logic tx_gave_up_flag;
    logic collided_flag;
    logic tx_ok_flag;
  } mcs_tx_rpt_s;

  // Configuration seen by the MAC core
  typedef struct packed {
    logic word_transfer_select;
    logic remote_dma_always_done;
    logic full_duplex_select;
    logic pad_suppress;
    logic late_collision_retry;
    mcs_loop_e loopback_select;
    logic crc_inhibit;
    logic check_only_receive;
    logic accept_any_unicast;
    logic accept_multicast;
    logic accept_broadcast;
    logic accept_runt;
    logic save_error_frames;
    logic [6:0] pad_min_bytes;
    logic [6:0] frame_gap;
    logic [6:0] gap_segment_one;
    logic [6:0] gap_segment_two;
  } mcs_cfg_s;
endpackage

// *** design/mcs_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module mcs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest full and empty from the fill count
  assign in_ready = (count_ff != DEPTH_C);
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];

  // Storage, written only on an accepted push
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_C) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_C) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// *** design/mcs_regs.sv ***
// Ethernet MAC configuration and status registers on the local CPU bus
`timescale 1ns/10ps
module mcs_regs #(
  parameter bit ISA_STYLE_BUS = 1'b1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out_ff,
  output logic bus_data_oe_ff,
  input wire logic bus_rd_n,
  input wire logic bus_wr_n,
  output logic irq_pin_ff,
  input wire logic dma_start,
  input wire logic dma_done,
  input wire logic counter_overflow,
  input wire logic ring_overwrite,
  input wire logic tx_rpt_valid,
  input wire mcs_pkg::mcs_tx_rpt_s tx_rpt,
  input wire logic rx_rpt_valid,
  input wire mcs_pkg::mcs_rx_rpt_s rx_rpt,
  output logic rx_rpt_ready_ff,
  output logic dma_complete_ff,
  output mcs_pkg::mcs_cfg_s cfg_ff
);
  import mcs_pkg::*;

  // Bus pins: two-stage synchronisers, third stage for edges
  logic [14:0] bus_s1_ff;
  logic [14:0] bus_s2_ff;
  logic rd_s3_ff;
  logic wr_s3_ff;
  logic [4:0] rd_addr_ff;
  wire [14:0] bus_pins = {bus_addr, bus_data_in, ~bus_rd_n, ~bus_wr_n};
  wire [4:0] s_addr = bus_s2_ff[14:10];
  wire [7:0] s_data = bus_s2_ff[9:2];
  wire s_rd = bus_s2_ff[1];
  wire s_wr = bus_s2_ff[0];
  wire wr_go = s_wr && !wr_s3_ff;
  wire rd_go = s_rd && !rd_s3_ff;
  wire rd_end = !s_rd && rd_s3_ff;

  // Synchroniser chain
  // Address and data settle before the strobe, so they share its stages
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_s1_ff <= '0;
      bus_s2_ff <= '0;
      rd_s3_ff <= 1'b0;
      wr_s3_ff <= 1'b0;
    end else begin
      bus_s1_ff <= bus_pins;
      bus_s2_ff <= bus_s1_ff;
      rd_s3_ff <= s_rd;
      wr_s3_ff <= s_wr;
    end
  end

  // Write decode
  wire wr_irq_status = wr_go && (s_addr == OFS_IRQ_STATUS);
  wire wr_rx_cfg = wr_go && (s_addr == OFS_RX_CFG_STAT);
  wire wr_tx_cfg = wr_go && (s_addr == OFS_TX_CONFIG);
  wire wr_data_cfg = wr_go && (s_addr == OFS_DATA_CONFIG);
  wire wr_irq_mask = wr_go && (s_addr == OFS_IRQ_MASK);
  wire wr_gap_one = wr_go && (s_addr == OFS_GAP_ONE);
  wire wr_gap_two = wr_go && (s_addr == OFS_GAP_TWO);
  wire wr_frame_gap = wr_go && (s_addr == OFS_FRAME_GAP);

  // Register state
  logic [6:0] irq_enable_mask_reg_ff;
  logic [6:0] irq_status_reg_ff;
  logic [6:0] rx_status_reg_ff;
  mcs_tx_rpt_s tx_status_reg_ff;
  logic irq_polarity_ff;
  logic rx_status_held_ff;

  // Interrupt enables, reserved bit 7 dropped
  // seven enables
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable_mask_reg_ff <= RST_IRQ_MASK;
    end else if (wr_irq_mask) begin
      irq_enable_mask_reg_ff <= s_data[6:0];
    end
  end

  // Data configuration
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff.word_transfer_select <= 1'b0;
      cfg_ff.remote_dma_always_done <= 1'b0;
    end else if (wr_data_cfg) begin
      cfg_ff.word_transfer_select <= s_data[0];
      cfg_ff.remote_dma_always_done <= s_data[7];
    end
  end

  // Transmit configuration
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff.full_duplex_select <= 1'b0;
      cfg_ff.pad_suppress <= 1'b0;
      cfg_ff.late_collision_retry <= 1'b0;
      cfg_ff.loopback_select <= MCS_LB_NORMAL;
      cfg_ff.crc_inhibit <= 1'b0;
    end else if (wr_tx_cfg) begin
      cfg_ff.full_duplex_select <= s_data[7];
      cfg_ff.pad_suppress <= s_data[6];
      cfg_ff.late_collision_retry <= s_data[5];
      cfg_ff.loopback_select <= mcs_loop_e'(s_data[2:1]);
      cfg_ff.crc_inhibit <= s_data[0];
    end
  end

  // Pad target loads with the pad bit, so the core never sees them disagree
  // pad length
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff.pad_min_bytes <= MIN_FRAME_BYTES;
    end else if (wr_tx_cfg) begin
      cfg_ff.pad_min_bytes <= s_data[6] ? 7'h00 : MIN_FRAME_BYTES;
    end
  end

  // Receive configuration
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_polarity_ff <= RST_IRQ_POLARITY;
      cfg_ff.check_only_receive <= 1'b0;
      cfg_ff.accept_any_unicast <= 1'b0;
      cfg_ff.accept_multicast <= 1'b0;
      cfg_ff.accept_broadcast <= 1'b0;
      cfg_ff.accept_runt <= 1'b0;
      cfg_ff.save_error_frames <= 1'b0;
    end else if (wr_rx_cfg) begin
      irq_polarity_ff <= s_data[6];
      cfg_ff.check_only_receive <= s_data[5];
      cfg_ff.accept_any_unicast <= s_data[4];
      cfg_ff.accept_multicast <= s_data[3];
      cfg_ff.accept_broadcast <= s_data[2];
      cfg_ff.accept_runt <= s_data[1];
      cfg_ff.save_error_frames <= s_data[0];
    end
  end

  // Inter-frame gap registers, 7 bits each
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff.frame_gap <= RST_FRAME_GAP;
      cfg_ff.gap_segment_one <= RST_GAP_ONE;
      cfg_ff.gap_segment_two <= RST_GAP_TWO;
    end else begin
      if (wr_frame_gap) begin
        cfg_ff.frame_gap <= s_data[6:0];
      end
      if (wr_gap_one) begin
        cfg_ff.gap_segment_one <= s_data[6:0];
      end
      if (wr_gap_two) begin
        cfg_ff.gap_segment_two <= s_data[6:0];
      end
    end
  end

  // Transmit status follows each transmit report
  // transmit flags
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_status_reg_ff <= '0;
    end else if (tx_rpt_valid) begin
      tx_status_reg_ff <= tx_rpt;
    end
  end

  // Receive report queue
  // Hazard: a push while the queue is full is lost; ready lags one cycle
  mcs_rx_rpt_s q_data;
  logic q_valid;
  logic q_in_ready;
  wire rx_read_done = rd_end && (rd_addr_ff == OFS_RX_CFG_STAT);
  wire q_pop = q_valid && (!rx_status_held_ff || rx_read_done);

  mcs_fifo #(
    .WIDTH($bits(mcs_rx_rpt_s)),
    .DEPTH(RX_RPT_DEPTH)
  ) u_rx_q (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_data(rx_rpt),
    .in_valid(rx_rpt_valid),
    .in_ready(q_in_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_pop)
  );

  // Receive status loads the next report once the last was read
  // receive flags
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_status_reg_ff <= '0;
      rx_status_held_ff <= 1'b0;
      rx_rpt_ready_ff <= 1'b0;
    end else begin
      rx_rpt_ready_ff <= q_in_ready;
      if (q_pop) begin
        rx_status_reg_ff <= q_data;
        rx_status_held_ff <= 1'b1;
      end else if (rx_read_done) begin
        rx_status_held_ff <= 1'b0;
      end
    end
  end

  // Interrupt events, one per status bit
  wire dma_evt = dma_done || (cfg_ff.remote_dma_always_done && dma_start);
  wire rx_err_evt = q_pop && (q_data.checksum_bad_flag || q_data.alignment_error_flag
    || q_data.rx_buffer_overrun_flag || q_data.missed_frame_flag);
  wire rx_ok_evt = q_pop && q_data.rx_intact_flag;
  wire tx_err_evt = tx_rpt_valid && tx_rpt.tx_gave_up_flag;
  wire tx_ok_evt = tx_rpt_valid && tx_rpt.tx_ok_flag;
  logic [6:0] irq_events;
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_BIT_DMA] = dma_evt;
    irq_events[IRQ_BIT_CNT] = counter_overflow;
    irq_events[IRQ_BIT_OVW] = ring_overwrite;
    irq_events[IRQ_BIT_TXE] = tx_err_evt;
    irq_events[IRQ_BIT_RXE] = rx_err_evt;
    irq_events[IRQ_BIT_PTX] = tx_ok_evt;
    irq_events[IRQ_BIT_PRX] = rx_ok_evt;
  end

  // Sticky flags; a new event wins over a write-one clear
  // write one clears
  wire [6:0] irq_clear = wr_irq_status ? s_data[6:0] : 7'h00;
  wire [6:0] nxt_irq_status = (irq_status_reg_ff & ~irq_clear) | irq_events;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status_reg_ff <= '0;
    end else begin
      irq_status_reg_ff <= nxt_irq_status;
    end
  end

  // Pin level from pending state and bus-family polarity
  // pending interrupt
  wire irq_pending = |(irq_status_reg_ff & irq_enable_mask_reg_ff);
  wire pin_high_active = ISA_STYLE_BUS ? irq_polarity_ff : !irq_polarity_ff;
  wire nxt_irq_pin = pin_high_active ? irq_pending : !irq_pending;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      // Pin rests at its inactive level through reset
      irq_pin_ff <= !ISA_STYLE_BUS;
      dma_complete_ff <= 1'b0;
    end else begin
      irq_pin_ff <= nxt_irq_pin;
      dma_complete_ff <= dma_evt;
    end
  end

  // Read multiplexer; unmapped and write-only offsets read zero
  // Reads have no side effect; only an ended rx status read frees it
  // reserved read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (s_addr)
      OFS_TX_STATUS: rd_mux = {tx_status_reg_ff.late_window_hit, 3'b000,
        tx_status_reg_ff.tx_gave_up_flag, tx_status_reg_ff.collided_flag, 1'b0,
        tx_status_reg_ff.tx_ok_flag};
      OFS_IRQ_STATUS: rd_mux = {1'b0, irq_status_reg_ff};
      OFS_RX_CFG_STAT: rd_mux = {1'b0, rx_status_reg_ff};
      OFS_GAP_ONE: rd_mux = {1'b0, cfg_ff.gap_segment_one};
      OFS_GAP_TWO: rd_mux = {1'b0, cfg_ff.gap_segment_two};
      OFS_FRAME_GAP: rd_mux = {1'b0, cfg_ff.frame_gap};
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data captured at strobe start, driven while strobe stays low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_data_out_ff <= 8'h00;
      bus_data_oe_ff <= 1'b0;
      rd_addr_ff <= 5'h00;
    end else begin
      bus_data_oe_ff <= s_rd;
      if (rd_go) begin
        bus_data_out_ff <= rd_mux;
        rd_addr_ff <= s_addr;
      end
    end
  end
endmodule

// *** test/mcs_regs_props.sv ***
// Concurrent checks on the MAC config/status register ports
`timescale 1ns/10ps
module mcs_regs_props #(
  parameter bit ISA_STYLE_BUS = 1'b1
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [4:0] bus_addr,
  input wire logic bus_rd_n,
  input wire logic [7:0] bus_data_out_ff,
  input wire logic bus_data_oe_ff,
  input wire logic irq_pin_ff,
  input wire logic dma_start,
  input wire logic dma_done,
  input wire logic rx_rpt_valid,
  input wire logic rx_rpt_ready_ff,
  input wire logic dma_complete_ff,
  input wire mcs_pkg::mcs_cfg_s cfg_ff
);
  import mcs_pkg::*;
  // One clock domain, reset disables all checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  gap_reset_a: assert property (!$past(arst_n) |-> cfg_ff.frame_gap == RST_FRAME_GAP)
    else $error("frame gap not at reset value");
  seg_reset_a: assert property (!$past(arst_n) |->
    cfg_ff.gap_segment_one == RST_GAP_ONE && cfg_ff.gap_segment_two == RST_GAP_TWO)
    else $error("gap segments not at reset value");
  irq_idle_a: assert property (!$past(arst_n) |-> ##1 irq_pin_ff == !ISA_STYLE_BUS)
    else $error("irq pin active after reset");
  pad_len_a: assert property (cfg_ff.pad_min_bytes ==
    (cfg_ff.pad_suppress ? 7'h00 : MIN_FRAME_BYTES))
    else $error("pad length disagrees with pad bit");
  dma_force_a: assert property (dma_start && cfg_ff.remote_dma_always_done |=>
    dma_complete_ff)
    else $error("forced dma completion missing");
  dma_cause_a: assert property ($rose(dma_complete_ff) |-> $past(dma_done) ||
    ($past(dma_start) && $past(cfg_ff.remote_dma_always_done)))
    else $error("dma completion without cause");
  rsvd_read_a: assert property (bus_data_oe_ff && bus_addr != OFS_TX_STATUS |->
    !bus_data_out_ff[7])
    else $error("reserved bit 7 read as one");
  read_open_a: assert property ($fell(bus_rd_n) |-> ##[2:4] bus_data_oe_ff)
    else $error("read data not driven in time");
  read_close_a: assert property ($rose(bus_rd_n) |-> ##[2:4] !bus_data_oe_ff)
    else $error("read data not released in time");
  ready_fall_a: assert property ($fell(rx_rpt_ready_ff) |->
    $past(rx_rpt_valid) || $past(rx_rpt_valid, 2))
    else $error("report queue full without push");
endmodule

// *** test/mcs_host.sv ***
// Host CPU model on the local register bus
`timescale 1ns/10ps
module mcs_host (
  input wire logic ref_clk,
  input wire logic [7:0] bus_data_out_ff,
  input wire logic bus_data_oe_ff,
  output logic [4:0] bus_addr,
  output logic [7:0] bus_data_in,
  output logic bus_rd_n,
  output logic bus_wr_n
);
  // Idle bus at time zero
  initial begin
    bus_addr = 5'h00;
    bus_data_in = 8'h00;
    bus_rd_n = 1'b1;
    bus_wr_n = 1'b1;
  end

  // Write strobe held four clocks, then four idle; data inverted after the idle clocks
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_data_in <= d;
    bus_wr_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    bus_wr_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus_data_in <= ~d;
  endtask

  // Read held until the device drives data, bounded wait
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output bit late);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd_n <= 1'b0;
    late = 1'b1;
    for (int n = 0; n < 12 && late; n++) begin
      @(posedge ref_clk);
      #1;
      late = (bus_data_oe_ff !== 1'b1);
    end
    d = bus_data_out_ff;
    @(posedge ref_clk);
    bus_rd_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask
endmodule

// *** test/test_mcs_regs.sv ***
// Self-checking bench for the MAC config/status registers
`timescale 1ns/10ps
module test_mcs_regs;
  import mcs_pkg::*;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] bus_addr;
  logic [7:0] bus_data_in;
  logic [7:0] bus_data_out_ff;
  logic bus_data_oe_ff;
  logic bus_rd_n;
  logic bus_wr_n;
  logic irq_pin_ff;
  logic [3:0] ev_in = 4'h0;
  logic tx_rpt_valid = 1'b0;
  mcs_tx_rpt_s tx_rpt = '0;
  logic rx_rpt_valid = 1'b0;
  mcs_rx_rpt_s rx_rpt = '0;
  logic rx_rpt_ready_ff;
  logic dma_complete_ff;
  mcs_cfg_s cfg_ff;
  int error_cnt = 0;
  int checks_done = 0;
  int n;
  logic [7:0] tx = 8'h00, dc = 8'h00, rc = 8'h40;
  logic [6:0] g1 = RST_GAP_ONE, g2 = RST_GAP_TWO, fg = RST_FRAME_GAP;
  logic [4:0] gofs[3] = '{OFS_GAP_ONE, OFS_GAP_TWO, OFS_FRAME_GAP};
  logic [6:0] grst[3] = '{RST_GAP_ONE, RST_GAP_TWO, RST_FRAME_GAP};
  logic [12:0] cfg_seq[8] = '{{OFS_TX_CONFIG, 8'hfb}, {OFS_TX_CONFIG, 8'h44},
    {OFS_TX_CONFIG, 8'h00}, {OFS_DATA_CONFIG, 8'hff}, {OFS_DATA_CONFIG, 8'h00},
    {OFS_RX_CFG_STAT, 8'h3f}, {OFS_RX_CFG_STAT, 8'h15}, {OFS_RX_CFG_STAT, 8'h6a}};

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  mcs_regs i_mcs_regs (
    .ref_clk(ref_clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
    .bus_data_out_ff(bus_data_out_ff), .bus_data_oe_ff(bus_data_oe_ff),
    .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .irq_pin_ff(irq_pin_ff),
    .dma_start(ev_in[3]), .dma_done(ev_in[2]), .counter_overflow(ev_in[1]),
    .ring_overwrite(ev_in[0]), .tx_rpt_valid(tx_rpt_valid), .tx_rpt(tx_rpt),
    .rx_rpt_valid(rx_rpt_valid), .rx_rpt(rx_rpt), .rx_rpt_ready_ff(rx_rpt_ready_ff),
    .dma_complete_ff(dma_complete_ff), .cfg_ff(cfg_ff)
  );

  mcs_host i_mcs_host (
    .ref_clk(ref_clk), .bus_data_out_ff(bus_data_out_ff), .bus_data_oe_ff(bus_data_oe_ff),
    .bus_addr(bus_addr), .bus_data_in(bus_data_in), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n)
  );

  // Comparison, verdict and access helpers
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic mcs_cfg_s exp_cfg();
    return {dc[0], dc[7], tx[7:5], tx[2:0], rc[5:0],
      (tx[6] ? 7'h00 : MIN_FRAME_BYTES), fg, g1, g2};
  endfunction

  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit late;
    i_mcs_host.rd(a, d, late);
    if (late) begin
      error_cnt++;
      conclude();
    end else begin
      chk($sformatf("reg %h", a), {56'h0, exp}, {56'h0, d});
    end
  endtask

  task automatic wcfg(input logic [4:0] a, input logic [7:0] v);
    i_mcs_host.wr(a, v);
    case (a)
      OFS_TX_CONFIG: tx = v;
      OFS_DATA_CONFIG: dc = v;
      OFS_RX_CFG_STAT: rc = v;
      OFS_GAP_ONE: g1 = v[6:0];
      OFS_GAP_TWO: g2 = v[6:0];
      OFS_FRAME_GAP: fg = v[6:0];
      default: ;
    endcase
    chk("cfg", {22'h0, exp_cfg()}, {22'h0, cfg_ff});
  endtask

  task automatic pin(input logic exp);
    #1;
    chk("irq pin", {63'h0, exp}, {63'h0, irq_pin_ff});
  endtask

  task automatic ev(input logic [3:0] v, input logic exp);
    @(posedge ref_clk);
    ev_in <= v;
    @(posedge ref_clk);
    ev_in <= 4'h0;
    #1;
    chk("dma complete", {63'h0, exp}, {63'h0, dma_complete_ff});
  endtask

  task automatic pulse_tx(input mcs_tx_rpt_s r);
    @(posedge ref_clk);
    tx_rpt <= r;
    tx_rpt_valid <= 1'b1;
    @(posedge ref_clk);
    tx_rpt_valid <= 1'b0;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("cfg", {22'h0, exp_cfg()}, {22'h0, cfg_ff});
    foreach (gofs[i]) begin
      rchk(gofs[i], {1'b0, grst[i]});
      wcfg(gofs[i], 8'hff);
      rchk(gofs[i], 8'h7f);
    end
    $display("test reset and gaps done");
    foreach (cfg_seq[i]) wcfg(cfg_seq[i][12:8], cfg_seq[i][7:0]);
    rchk(OFS_TX_CONFIG, 8'h00);
    rchk(5'h01, 8'h00);
    $display("test config done");
    pulse_tx(4'b1110);
    rchk(OFS_TX_STATUS, 8'h8c);
    rchk(OFS_IRQ_STATUS, 8'h08);
    i_mcs_host.wr(OFS_IRQ_STATUS, 8'h08);
    pulse_tx(4'b0001);
    i_mcs_host.wr(OFS_TX_STATUS, 8'hff);
    rchk(OFS_TX_STATUS, 8'h01);
    rchk(OFS_IRQ_STATUS, 8'h02);
    i_mcs_host.wr(OFS_IRQ_STATUS, 8'h02);
    $display("test tx status done");
    ev(4'b0111, 1'b1);
    rchk(OFS_IRQ_STATUS, 8'h70);
    pin(1'b0);
    for (int b = 4; b < 7; b++) begin
      i_mcs_host.wr(OFS_IRQ_MASK, 8'(1 << b));
      pin(1'b1);
    end
    i_mcs_host.wr(OFS_IRQ_MASK, 8'h8f);
    pin(1'b0);
    i_mcs_host.wr(OFS_IRQ_MASK, 8'h40);
    wcfg(OFS_RX_CFG_STAT, 8'h2a);
    pin(1'b0);
    i_mcs_host.wr(OFS_IRQ_STATUS, 8'h70);
    pin(1'b1);
    rchk(OFS_IRQ_STATUS, 8'h00);
    // Overflow event lands in the cycle the clear write acts; the event wins
    fork
      i_mcs_host.wr(OFS_IRQ_STATUS, 8'h20);
      begin
        repeat (3) @(posedge ref_clk);
        ev_in <= 4'b0010;
        @(posedge ref_clk);
        ev_in <= 4'h0;
      end
    join
    rchk(OFS_IRQ_STATUS, 8'h20);
    i_mcs_host.wr(OFS_IRQ_STATUS, 8'h20);
    wcfg(OFS_RX_CFG_STAT, 8'h6a);
    pin(1'b0);
    wcfg(OFS_DATA_CONFIG, 8'h80);
    ev(4'b1000, 1'b1);
    wcfg(OFS_DATA_CONFIG, 8'h00);
    ev(4'b1000, 1'b0);
    $display("test interrupts done");
    #1;
    n = 0;
    while (n < 8 && rx_rpt_ready_ff === 1'b1) begin
      @(posedge ref_clk);
      rx_rpt <= 7'h10 + 7'(n);
      rx_rpt_valid <= 1'b1;
      @(posedge ref_clk);
      rx_rpt_valid <= 1'b0;
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("queue refuses", 64'h0, {63'h0, rx_rpt_ready_ff});
    chk("pushes taken", 64'h1, {63'h0, n > 0});
    for (int k = 0; k < n; k++) rchk(OFS_RX_CFG_STAT, 8'h10 + 8'(k));
    rchk(OFS_IRQ_STATUS, 8'h45);
    $display("test rx queue done");
    conclude();
  end
endmodule

bind mcs_regs mcs_regs_props #(.ISA_STYLE_BUS(ISA_STYLE_BUS)) i_mcs_regs_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_rd_n(bus_rd_n),
  .bus_data_out_ff(bus_data_out_ff), .bus_data_oe_ff(bus_data_oe_ff),
  .irq_pin_ff(irq_pin_ff), .dma_start(dma_start), .dma_done(dma_done),
  .rx_rpt_valid(rx_rpt_valid), .rx_rpt_ready_ff(rx_rpt_ready_ff),
  .dma_complete_ff(dma_complete_ff), .cfg_ff(cfg_ff)
);
